// ==== src/lstc_top.sv ====
`timescale 1ns/10ps
`include "lstc_cfg.svh"
// What this block does
// - TX sends K28.5 until SYSREF realigns
// - RX holds SYNC until SYSREF realigns
// - Without requirement, TX starts alignment next boundary
// - Without requirement, RX releases SYNC next boundary
// - Delay field adds 0-15 cycles to realign
// - Always bit realigns on every SYSREF
// - Otherwise only the first SYSREF aligns
// - Alignment length field holds multiframes minus one
// - Code 00000 normal, 00001 K28.5 forever
// - Code 00010 syncs then repeats alignment sequence
// - Code 00011 sends D21.5 forever
// - Code 00101 sends RPAT, transmit only
// - Code 00111 sends JSPAT, transmit only
// - Top bit hands over to PRBS, data off
// - Alignment support enables sequence send and expect
module lstc_top
    import lstc_pkg::*;
#(
    parameter int LMFC_CYCLES = `LSTC_LMFC_CYCLES,
    parameter int ADDR_W      = 12
) (
    // Clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Timing and link pins
    input  wire logic                sysref,
    input  wire logic                resync_req,
    // Lane steering
    output lstc_pkg::lstc_tx_t       tx_ctl,
    output lstc_pkg::lstc_char_t     rx_expect,
    output logic                     sync_n,
    output logic                     lmfc_edge
);
    import lstc_pkg::*;

    typedef enum {
        LSTC_S_SYNC,
        LSTC_S_ILA,
        LSTC_S_DATA
    } lstc_state_t;

    localparam int NREG = 5;

    // Address decode shared by the read and write paths
    function automatic logic [NREG-1:0] lstc_dec(input logic [ADDR_W-1:0] a);
        logic [11:0] o;
        o = 12'(a);
        lstc_dec = {o == `LSTC_OFF_STATUS,
                    o == `LSTC_OFF_TEST,
                    o == `LSTC_OFF_ILA_LEN,
                    o == `LSTC_OFF_SYSREF,
                    o == `LSTC_OFF_ILA_SUP};
    endfunction : lstc_dec

    // Registers
    logic        ila_sup_q;
    logic        sr_always_q;
    logic [3:0]  sr_dly_q;
    logic        sr_resync_q;
    logic [7:0]  ila_len_q;
    logic [4:0]  test_q;

    // Link state
    lstc_state_t state_q;
    lstc_state_t state_d;
    logic [7:0]  mf_q;
    logic [7:0]  mf_d;
    logic        sysref_s;
    logic        resync_s;
    logic        sysref_prev_q;
    logic        resync_prev_q;
    logic        realign;
    logic        aligned;
    logic        lmfc_edge_w;
    logic        ila_pend_q;

    // Bus decode
    wire [NREG-1:0] hit      = lstc_dec(paddr);
    wire            mapped   = |hit;
    wire            setup    = psel & ~penable;
    wire            wr_fire  = psel & penable & pready & pwrite;
    wire [NREG-1:0] wr_hit   = wr_fire ? hit : '0;

    // Pin edges, read only from the second synchroniser stage
    wire sysref_evt = sysref_s & ~sysref_prev_q;
    wire resync_evt = resync_s & ~resync_prev_q;

    lstc_sr_cfg_t sr_cfg;
    assign sr_cfg = '{always_realign: sr_always_q, delay: sr_dly_q};

    lstc_sync2 #(
        .W (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({resync_req, sysref}),
        .q       ({resync_s, sysref_s})
    );

    lstc_lmfc #(
        .LMFC_CYCLES (LMFC_CYCLES)
    ) u_lmfc (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .cfg        (sr_cfg),
        .sysref_evt (sysref_evt),
        .lmfc_edge  (lmfc_edge_w),
        .realign    (realign),
        .aligned    (aligned)
    );

    // Test select decode
    wire tm_prbs  = test_q[`LSTC_TM_PRBS_BIT];
    wire tm_k28   = (test_q == `LSTC_TM_K28);
    wire tm_ila   = (test_q == `LSTC_TM_ILA);
    wire tm_d21   = (test_q == `LSTC_TM_D21);
    wire tm_rpat  = (test_q == `LSTC_TM_RPAT);
    wire tm_jspat = (test_q == `LSTC_TM_JSPAT);

    // Leaving the wait: SYSREF realign when required, else any boundary
    wire sync_go  = sr_resync_q ? realign : lmfc_edge_w;
    wire ila_last = (mf_q == ila_len_q);

    // Read images, one word per decoded register, indexed like the hit vector
    wire [31:0] rd_word [NREG];
    assign rd_word[0] = 32'(ila_sup_q) << `LSTC_ILA_SUP_BIT;
    assign rd_word[1] = (32'(sr_resync_q) << `LSTC_SR_RESYNC_BIT) |
                        (32'(sr_dly_q) << `LSTC_SR_DLY_LO) |
                        (32'(sr_always_q) << `LSTC_SR_ALWAYS_BIT);
    assign rd_word[2] = 32'(ila_len_q);
    assign rd_word[3] = 32'(test_q);
    // Logical not keeps the SYNC flag one bit wide before it is widened
    assign rd_word[4] = (32'(state_q == LSTC_S_DATA) << `LSTC_ST_DATA_BIT) |
                        (32'(!sync_n) << `LSTC_ST_SYNC_BIT) |
                        (32'(aligned) << `LSTC_ST_ALIGNED_BIT) |
                        (32'(state_q == LSTC_S_SYNC && sr_resync_q)
                             << `LSTC_ST_WAITSR_BIT) |
                        (32'(state_q == LSTC_S_ILA) << `LSTC_ST_ILA_BIT);

    // Unmapped offsets read as zero since no hit bit lets a word through
    wire [31:0] rd_or [NREG+1];
    assign rd_or[0] = 32'h0000_0000;
    for (genvar g = 0; g < NREG; g++) begin : g_rd
        assign rd_or[g+1] = rd_or[g] | ({32{hit[g]}} & rd_word[g]);
    end

    logic [31:0] rd_w;
    assign rd_w = rd_or[NREG];

    // APB: no wait state, yet every answer comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_w : 32'h0000_0000;
            // Status is read only, so a write to it is an error as well
            pslverr <= setup & (~mapped | (pwrite & hit[4]));
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ila_sup_q   <= `LSTC_RST_ILA_SUP;
            sr_always_q <= `LSTC_RST_ALWAYS;
            sr_dly_q    <= `LSTC_RST_DLY;
            sr_resync_q <= `LSTC_RST_RESYNC;
            ila_len_q   <= `LSTC_RST_ILA_LEN;
            test_q      <= `LSTC_RST_TEST;
        end else if (ce) begin
            if (wr_hit[0]) begin
                ila_sup_q <= pwdata[`LSTC_ILA_SUP_BIT];
            end
            if (wr_hit[1]) begin
                sr_always_q <= pwdata[`LSTC_SR_ALWAYS_BIT];
                sr_dly_q    <= pwdata[`LSTC_SR_DLY_HI:`LSTC_SR_DLY_LO];
                sr_resync_q <= pwdata[`LSTC_SR_RESYNC_BIT];
            end
            if (wr_hit[2]) begin
                ila_len_q <= pwdata[`LSTC_ILEN_HI:0];
            end
            if (wr_hit[3]) begin
                test_q <= pwdata[`LSTC_TM_HI:0];
            end
        end
    end

    // Link alignment sequencing
    always_comb begin
        state_d = state_q;
        mf_d    = mf_q;
        case (state_q)
            LSTC_S_SYNC: begin
                if (sync_go) begin
                    mf_d    = 8'h00;
                    state_d = ila_sup_q ? LSTC_S_ILA : LSTC_S_DATA;
                end
            end
            LSTC_S_ILA: begin
                if (lmfc_edge_w) begin
                    if (!ila_last) begin
                        mf_d = mf_q + 8'h01;
                    end else if (tm_ila) begin
                        mf_d = 8'h00;
                    end else begin
                        state_d = LSTC_S_DATA;
                    end
                end
            end
            LSTC_S_DATA: begin
                if (ila_pend_q && lmfc_edge_w) begin
                    mf_d    = 8'h00;
                    state_d = LSTC_S_ILA;
                end
            end
            default: begin
                state_d = LSTC_S_SYNC;
            end
        endcase
        // A re-sync request from the far side restarts the handshake
        if (resync_evt) begin
            state_d = LSTC_S_SYNC;
            mf_d    = 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= LSTC_S_SYNC;
            mf_q          <= 8'h00;
            sysref_prev_q <= 1'b0;
            resync_prev_q <= 1'b0;
            ila_pend_q    <= 1'b0;
        end else if (ce) begin
            state_q       <= state_d;
            mf_q          <= mf_d;
            sysref_prev_q <= sysref_s;
            resync_prev_q <= resync_s;
            // Repeated sequences are wanted even with support disabled
            ila_pend_q    <= tm_ila;
        end
    end

    // Stream selection from state and test select
    lstc_char_t link_chr;
    lstc_tx_t   tx_d;
    // Follows the next state so steering and SYNC change on the same edge
    assign link_chr = (state_d == LSTC_S_SYNC) ? LSTC_CH_K28_5 :
                      (state_d == LSTC_S_ILA)  ? LSTC_CH_ILA   :
                      LSTC_CH_DATA;

    // Anything not decoded below, reserved codes included, is normal
    always_comb begin
        tx_d.chr      = link_chr;
        tx_d.data_en  = 1'b1;
        tx_d.prbs_en  = 1'b0;
        tx_d.prbs_sel = 4'h0;
        if (tm_prbs) begin
            tx_d.chr      = LSTC_CH_PRBS;
            tx_d.data_en  = 1'b0;
            tx_d.prbs_en  = 1'b1;
            tx_d.prbs_sel = test_q[`LSTC_TM_SEL_HI:0];
        end else if (tm_k28) begin
            tx_d.chr = LSTC_CH_K28_5;
        end else if (tm_d21) begin
            tx_d.chr = LSTC_CH_D21_5;
        end else if (tm_rpat) begin
            tx_d.chr = LSTC_CH_RPAT;
        end else if (tm_jspat) begin
            tx_d.chr = LSTC_CH_JSPAT;
        end
    end

    // Receive side never sees the transmit-only patterns
    lstc_char_t rx_d;
    assign rx_d = tm_k28 ? LSTC_CH_K28_5 :
                  tm_d21 ? LSTC_CH_D21_5 :
                  link_chr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ctl    <= '{chr: LSTC_CH_K28_5, data_en: 1'b1,
                           prbs_en: 1'b0, prbs_sel: 4'h0};
            rx_expect <= LSTC_CH_K28_5;
            sync_n    <= 1'b0;
            lmfc_edge <= 1'b0;
        end else if (ce) begin
            tx_ctl    <= tx_d;
            rx_expect <= rx_d;
            sync_n    <= (state_d != LSTC_S_SYNC);
            lmfc_edge <= lmfc_edge_w;
        end
    end
endmodule : lstc_top

// ==== common/lstc_cfg.svh ====
`ifndef LSTC_CFG_SVH
`define LSTC_CFG_SVH

// Register byte offsets
`define LSTC_OFF_ILA_SUP     12'h008
`define LSTC_OFF_SYSREF      12'h010
`define LSTC_OFF_ILA_LEN     12'h014
`define LSTC_OFF_TEST        12'h018
`define LSTC_OFF_STATUS      12'h038

// Field positions
`define LSTC_ILA_SUP_BIT     0
`define LSTC_SR_ALWAYS_BIT   0
`define LSTC_SR_DLY_LO       8
`define LSTC_SR_DLY_HI       11
`define LSTC_SR_RESYNC_BIT   16
`define LSTC_ILEN_HI         7
`define LSTC_TM_HI           4
`define LSTC_TM_PRBS_BIT     4
`define LSTC_TM_SEL_HI       3

// Status fields
`define LSTC_ST_DATA_BIT     0
`define LSTC_ST_SYNC_BIT     1
`define LSTC_ST_ALIGNED_BIT  2
`define LSTC_ST_WAITSR_BIT   3
`define LSTC_ST_ILA_BIT      4

// Reset values
`define LSTC_RST_ILA_SUP     1'b1
`define LSTC_RST_ALWAYS      1'b0
`define LSTC_RST_DLY         4'h0
`define LSTC_RST_RESYNC      1'b0
`define LSTC_RST_ILA_LEN     8'h03
`define LSTC_RST_TEST        5'h00

// Test select codes
`define LSTC_TM_NORMAL       5'h00
`define LSTC_TM_K28          5'h01
`define LSTC_TM_ILA          5'h02
`define LSTC_TM_D21          5'h03
`define LSTC_TM_RPAT         5'h05
`define LSTC_TM_JSPAT        5'h07

// Defaults of structural parameters
`define LSTC_LMFC_CYCLES     16
`define LSTC_SYNC_STAGES     2

`endif

// ==== common/lstc_pkg.sv ====
package lstc_pkg;

    // Character stream a lane sends, or expects to receive
    typedef enum logic [2:0] {
        LSTC_CH_DATA,
        LSTC_CH_K28_5,
        LSTC_CH_ILA,
        LSTC_CH_D21_5,
        LSTC_CH_RPAT,
        LSTC_CH_JSPAT,
        LSTC_CH_PRBS
    } lstc_char_t;

    // Transmit path steering
    typedef struct packed {
        lstc_char_t  chr;
        logic        data_en;
        logic        prbs_en;
        logic [3:0]  prbs_sel;
    } lstc_tx_t;

    // Alignment settings handed to the counter
    typedef struct packed {
        logic        always_realign;
        logic [3:0]  delay;
    } lstc_sr_cfg_t;

endpackage : lstc_pkg

// ==== src/lstc_sync2.sv ====
`timescale 1ns/10ps
// Two-stage synchroniser; only the second stage leaves this module
module lstc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : lstc_sync2

// ==== src/lstc_lmfc.sv ====
`timescale 1ns/10ps
`include "lstc_cfg.svh"
// Local multiframe counter with SYSREF re-alignment
module lstc_lmfc
    import lstc_pkg::*;
#(
    parameter int LMFC_CYCLES = `LSTC_LMFC_CYCLES
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    ce,
    // Control
    input  wire lstc_pkg::lstc_sr_cfg_t  cfg,
    input  wire logic                    sysref_evt,
    // Status
    output logic                         lmfc_edge,
    output logic                         realign,
    output logic                         aligned
);
    localparam int CW = (LMFC_CYCLES > 1) ? $clog2(LMFC_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(LMFC_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [3:0]    dly_q;
    logic          pend_q;
    wire           accept = sysref_evt & (cfg.always_realign | ~aligned);
    wire           fire   = pend_q & (dly_q == 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= '0;
            dly_q     <= 4'h0;
            pend_q    <= 1'b0;
            aligned   <= 1'b0;
            lmfc_edge <= 1'b0;
            realign   <= 1'b0;
        end else if (ce) begin
            realign   <= fire;
            lmfc_edge <= fire | (~fire & (cnt_q == LAST));
            if (accept) begin
                // A later event restarts the delay rather than stacking
                pend_q  <= 1'b1;
                dly_q   <= cfg.delay;
                aligned <= 1'b1;
            end else if (fire) begin
                pend_q <= 1'b0;
            end else if (pend_q) begin
                dly_q <= dly_q - 4'h1;
            end
            if (fire || cnt_q == LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end
endmodule : lstc_lmfc

// ==== tb/lstc_chk.sv ====
`timescale 1ns/10ps
module lstc_chk
    import lstc_pkg::*;
(
    // Clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // Bus
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Link
    input wire logic                resync_req,
    input wire lstc_pkg::lstc_tx_t  tx_ctl,
    input wire lstc_pkg::lstc_char_t rx_expect,
    input wire logic                sync_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("stale data");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_prbs_data_off: assert property (tx_ctl.prbs_en |->
        !tx_ctl.data_en && tx_ctl.chr == LSTC_CH_PRBS) else $error("prbs with data");
    a_sync_no_data: assert property (!sync_n |->
        !(tx_ctl.chr inside {LSTC_CH_DATA, LSTC_CH_ILA})) else $error("data during sync");
    a_rx_tx_only: assert property (!(rx_expect inside
        {LSTC_CH_RPAT, LSTC_CH_JSPAT, LSTC_CH_PRBS})) else $error("rx tx-only code");
    a_resync_sync_low: assert property ($rose(resync_req) |-> ##[2:6] !sync_n)
        else $error("sync not asserted");
endmodule : lstc_chk

bind lstc_top lstc_chk lstc_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resync_req(resync_req), .tx_ctl(tx_ctl),
    .rx_expect(rx_expect), .sync_n(sync_n)
);

// ==== tb/lstc_conv_model.sv ====
`timescale 1ns/10ps
// Far-side converter: raises SYSREF and link re-sync on command
module lstc_conv_model (
    // Clock
    input  wire logic pclk,
    // Commands
    input  wire logic sr_go,
    input  wire logic rs_go,
    // Pins
    output logic      sysref,
    output logic      resync_req
);
    logic [2:0] sr_q = 3'h0;
    logic [2:0] rs_q = 3'h0;

    // Pulses outlast the two-flop synchroniser so no edge is lost
    always_ff @(posedge pclk) begin
        sr_q <= sr_go ? 3'h4 : ((sr_q == 3'h0) ? 3'h0 : sr_q - 3'h1);
        rs_q <= rs_go ? 3'h4 : ((rs_q == 3'h0) ? 3'h0 : rs_q - 3'h1);
    end
    assign sysref     = (sr_q != 3'h0);
    assign resync_req = (rs_q != 3'h0);
endmodule : lstc_conv_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "lstc_cfg.svh"
module tb_top;
    import lstc_pkg::*;
    localparam int LMC = 4;
    logic        pclk, presetn, ce, psel, penable, pwrite, sr_go, rs_go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, sysref, resync_req, sync_n, lmfc_edge;
    lstc_tx_t    tx_ctl;
    lstc_char_t  rx_expect;
    logic [32:0] exq[$];
    logic [32:0] exp_v;
    int          n_fail = 0, cmp_count = 0, seed = 9845, n0, n15, n, L, h, rs;
    logic [4:0]  tm_c [7] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h1a, 5'h04, 5'h00};
    lstc_char_t  tm_x [7] = '{LSTC_CH_K28_5, LSTC_CH_D21_5, LSTC_CH_RPAT, LSTC_CH_JSPAT,
                              LSTC_CH_PRBS, LSTC_CH_DATA, LSTC_CH_DATA};
    wire [4:0]   tx_sum = {tx_ctl.chr, tx_ctl.data_en, tx_ctl.prbs_en};

    lstc_top #(.LMFC_CYCLES(LMC)) lstc_top_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysref(sysref), .resync_req(resync_req), .tx_ctl(tx_ctl),
        .rx_expect(rx_expect), .sync_n(sync_n), .lmfc_edge(lmfc_edge)
    );
    lstc_conv_model lstc_conv_model_inst (
        .pclk(pclk), .sr_go(sr_go), .rs_go(rs_go), .sysref(sysref), .resync_req(resync_req)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Expected {error, data} is queued before the request goes out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exq.push_back(e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d, {e, 32'h0});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b0, a, 32'h0, {e, d});
    endtask : rd

    always @(posedge pclk) begin
        if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
            exp_v = exq.pop_front();
            chk({31'h0, pslverr}, {31'h0, exp_v[32]});
            if (pwrite === 1'b0)
                chk(prdata, exp_v[31:0]);
        end
    end

    task automatic pulse(input logic s);
        if (s)
            sr_go <= 1'b1;
        else
            rs_go <= 1'b1;
        @(posedge pclk);
        sr_go <= 1'b0;
        rs_go <= 1'b0;
        @(posedge pclk);
    endtask : pulse

    task automatic wait_sync(output int c);
        c = 0;
        while (sync_n !== 1'b1 && c < 200) begin
            @(posedge pclk);
            c++;
        end
    endtask : wait_sync

    task automatic watch(input int cyc, output int hits, output int rises);
        logic prev;
        hits = 0;
        rises = 0;
        prev = 1'b0;
        repeat (cyc) begin
            @(posedge pclk);
            hits += (tx_ctl.chr === LSTC_CH_ILA);
            rises += (tx_ctl.chr === LSTC_CH_ILA) && !prev;
            prev = (tx_ctl.chr === LSTC_CH_ILA);
        end
    endtask : watch

    initial begin
        #800000;
        n_fail++;
        stop_test();
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, sr_go, rs_go} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`LSTC_OFF_ILA_SUP, 32'h1, 1'b0);
        rd(`LSTC_OFF_SYSREF, 32'h0, 1'b0);
        rd(`LSTC_OFF_ILA_LEN, 32'h3, 1'b0);
        rd(`LSTC_OFF_TEST, 32'h0, 1'b0);
        rd(12'h01c, 32'h0, 1'b1);
        wr(`LSTC_OFF_STATUS, 32'h1, 1'b1);
        r = $random(seed);
        wr(`LSTC_OFF_SYSREF, r, 1'b0);
        rd(`LSTC_OFF_SYSREF, r & 32'h10f01, 1'b0);
        r = $random(seed);
        wr(`LSTC_OFF_TEST, r, 1'b0);
        rd(`LSTC_OFF_TEST, r & 32'h1f, 1'b0);
        wr(`LSTC_OFF_TEST, 32'h0, 1'b0);
        wr(`LSTC_OFF_SYSREF, 32'h0, 1'b0);
        L = 3 + ({$random(seed)} % 4);
        wr(`LSTC_OFF_ILA_LEN, 32'(L), 1'b0);
        rd(`LSTC_OFF_ILA_LEN, 32'(L), 1'b0);
        repeat (60) @(posedge pclk);
        // Re-sync without SYSREF: alignment starts at a boundary
        pulse(1'b0);
        n = 0;
        while (tx_ctl.chr !== LSTC_CH_ILA && n < 100) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (tx_ctl.chr === LSTC_CH_ILA && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n), 32'((L + 1) * LMC));
        chk({31'h0, sync_n}, 32'h1);
        chk(32'(tx_ctl.chr), 32'(LSTC_CH_DATA));
        // Re-sync that waits for SYSREF
        wr(`LSTC_OFF_SYSREF, 32'h10000, 1'b0);
        pulse(1'b0);
        repeat (40) @(posedge pclk);
        chk({31'h0, sync_n}, 32'h0);
        chk(32'(tx_ctl.chr), 32'(LSTC_CH_K28_5));
        pulse(1'b1);
        wait_sync(n0);
        chk({31'h0, sync_n}, 32'h1);
        pulse(1'b0);
        repeat (8) @(posedge pclk);
        pulse(1'b1);
        repeat (40) @(posedge pclk);
        chk({31'h0, sync_n}, 32'h0);
        wr(`LSTC_OFF_SYSREF, 32'h10f01, 1'b0);
        pulse(1'b1);
        wait_sync(n15);
        chk({31'h0, sync_n}, 32'h1);
        chk(32'(n15 - n0), 32'd15);
        repeat (60) @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            wr(`LSTC_OFF_TEST, 32'(tm_c[i]), 1'b0);
            repeat (4) @(posedge pclk);
            chk(32'(tx_sum), 32'({tm_x[i], i != 4, i == 4}));
            chk(32'(rx_expect), 32'(i < 2 ? tm_x[i] : LSTC_CH_DATA));
            if (i == 4)
                chk(32'(tx_ctl.prbs_sel), 32'ha);
        end
        // Support off: re-sync must skip the alignment sequence
        wr(`LSTC_OFF_SYSREF, 32'h0, 1'b0);
        wr(`LSTC_OFF_ILA_SUP, 32'h0, 1'b0);
        pulse(1'b0);
        watch(60, h, rs);
        chk(32'(h), 32'h0);
        wr(`LSTC_OFF_TEST, 32'h2, 1'b0);
        watch(150, h, rs);
        chk(32'(rs), 32'h1);
        chk(32'(h >= 2 * (L + 1) * LMC), 32'h1);
        rd(`LSTC_OFF_STATUS, 32'h14, 1'b0);
        stop_test();
    end
endmodule : tb_top
